// ==== logic/fcad_params.svh ====
`ifndef FCAD_PARAMS_SVH
`define FCAD_PARAMS_SVH
// Register byte addresses.
`define FCAD_ADDR_CTRL7     8'h0B
`define FCAD_ADDR_CTRL6     8'h0A
`define FCAD_ADDR_CTRL3     8'h02
`define FCAD_ADDR_RSVD      8'h0C
`define FCAD_ADDR_RAMCTL    8'h0D
`define FCAD_ADDR_TAP       8'h0E
`define FCAD_ADDR_WHIGH     8'h0F
`define FCAD_ADDR_WMID      8'h10
`define FCAD_ADDR_WLOW      8'h11
`define FCAD_ADDR_RHIGH     8'h12
`define FCAD_ADDR_RMID      8'h13
`define FCAD_ADDR_RLOW      8'h14
`define FCAD_ADDR_DETECT    8'h15
// Field positions.
`define FCAD_BIT_CLEAR      0
`define FCAD_BIT_WREN       1
`define FCAD_BIT_RDEN       2
`define FCAD_BIT_SLOT0      4
`define FCAD_BIT_RAMP_LO    6
`define FCAD_BIT_SLOT1      5
`define FCAD_BIT_SLOT2      4
`define FCAD_BIT_CONV       6
`define FCAD_BIT_ZRL_LO     5
`define FCAD_BIT_AUTOEN     7
// Reset values and masks.
`define FCAD_RST_BYTE       8'h00
`define FCAD_RST_COEF       24'h000000
`define FCAD_RAMCTL_MASK    8'h07
`define FCAD_RSVD_MASK      8'h77
`define FCAD_DETECT_MASK    8'hE0
`define FCAD_CLEAR_LAST     8'hFF
`endif

// ==== logic/fcad_pkg.sv ====
package fcad_pkg;
  // Register write strobe with its address and data.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } fcad_wr_s;
  // Coefficient RAM clearing sequence.
  typedef enum logic [1:0] {
    FCAD_IDLE  = 2'b01,
    FCAD_CLEAR = 2'b10
  } fcad_state_e;
endpackage : fcad_pkg

// ==== logic/fcad_regs.sv ====
`timescale 1ns/1ns
`include "fcad_params.svh"
// Contract
// - Slot select lowest bit, default zero.
// - Two-bit attenuation ramp speed, default slowest.
// - Clear bit loads RAM initial values.
// - RAM writes only while write enable set.
// - Readout valid only while read enable set.
// - Eight-bit tap address, reset zero.
// - Three write bytes form coefficient, MSB first.
// - Three read-only bytes show coefficient, MSB first.
// - Three-bit detected speed mode, read only.
// - Two-bit zero run length select, default longest.
// - Auto PCM/DSD switching enable, default off.
// - Read-only actual conversion mode bit.
// - Upper slot bits elsewhere, combined to three.
module fcad_regs #(
  parameter int TAPS = 256
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // Decoded serial control port access.
  input  wire fcad_pkg::fcad_wr_s regWr,
  input  wire logic [7:0]       rdAddr,
  output logic [7:0]            rdData,
  // State from the converter core.
  input  wire logic [2:0]       detectedSpeedMode,
  input  wire logic             actualConversionMode,
  // Controls to the converter core.
  output logic [2:0]            tdmSlotSelect,
  output logic [1:0]            attenRampSpeed,
  output logic [1:0]            zeroRunLengthSelect,
  output logic                  autoFormatSwitchEn,
  output logic                  clearBusy
);
  ////////////////////////////////////////////////////////////////////////////
  // Control bytes.
  logic [7:0]  ctrl6;
  logic [7:0]  ctrl7;
  logic [7:0]  rsvd;
  logic [7:0]  ramCtl;
  logic [7:0]  tapAddr;
  logic [23:0] writeValue;
  logic [23:0] readValue;
  logic [7:0]  detectCtl;
  logic [23:0] coefficientRam [TAPS];
  fcad_pkg::fcad_state_e state;
  fcad_pkg::fcad_state_e next_state;
  logic [7:0]  clearPtr;

  function automatic logic hit(input logic [7:0] a);
    hit = regWr.wr && (regWr.addr == a);
  endfunction : hit

  // Byte write decode.
  wire wrCtl6  = hit(`FCAD_ADDR_CTRL6);
  wire wrCtl7  = hit(`FCAD_ADDR_CTRL7);
  wire wrRsvd  = hit(`FCAD_ADDR_RSVD);
  wire wrRam   = hit(`FCAD_ADDR_RAMCTL);
  wire wrTap   = hit(`FCAD_ADDR_TAP);
  wire wrHigh  = hit(`FCAD_ADDR_WHIGH);
  wire wrMid   = hit(`FCAD_ADDR_WMID);
  wire wrLow   = hit(`FCAD_ADDR_WLOW);
  wire wrDet   = hit(`FCAD_ADDR_DETECT);
  wire clearGo = wrRam && regWr.data[`FCAD_BIT_CLEAR];
  wire writeEn = ramCtl[`FCAD_BIT_WREN];
  wire readEn  = ramCtl[`FCAD_BIT_RDEN];

  // Storing the low byte commits the assembled word; writes are blocked otherwise.
  wire [23:0] wordIn  = {writeValue[23:8], regWr.data};
  wire        commit  = wrLow && writeEn && (state == fcad_pkg::FCAD_IDLE);

  // Control register storage.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl6      <= `FCAD_RST_BYTE;
      ctrl7      <= `FCAD_RST_BYTE;
      rsvd       <= `FCAD_RST_BYTE;
      ramCtl     <= `FCAD_RST_BYTE;
      tapAddr    <= `FCAD_RST_BYTE;
      writeValue <= `FCAD_RST_COEF;
      detectCtl  <= `FCAD_RST_BYTE;
    end else begin
      if (wrCtl6) ctrl6 <= regWr.data;
      if (wrCtl7) ctrl7 <= regWr.data;
      if (wrRsvd) rsvd <= regWr.data & `FCAD_RSVD_MASK;
      if (wrRam) ramCtl <= regWr.data & `FCAD_RAMCTL_MASK;
      if (wrTap) tapAddr <= regWr.data;
      if (wrHigh) writeValue[23:16] <= regWr.data;
      if (wrMid) writeValue[15:8] <= regWr.data;
      if (wrLow) writeValue[7:0] <= regWr.data;
      if (wrDet) detectCtl <= regWr.data & `FCAD_DETECT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clear sequencer walks every tap; it holds off writes while running, since
  // a parallel clear of the whole array would not map to a RAM macro.
  always_comb begin
    next_state = state;
    case (state)
      fcad_pkg::FCAD_IDLE:  if (clearGo) next_state = fcad_pkg::FCAD_CLEAR;
      fcad_pkg::FCAD_CLEAR: if (clearPtr == 8'(TAPS - 1)) next_state = fcad_pkg::FCAD_IDLE;
      default:              next_state = fcad_pkg::FCAD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= fcad_pkg::FCAD_IDLE;
      clearPtr <= `FCAD_RST_BYTE;
    end else begin
      state    <= next_state;
      clearPtr <= (state == fcad_pkg::FCAD_CLEAR) ? clearPtr + 8'h01 : `FCAD_RST_BYTE;
    end
  end

  // RAM port: one write per cycle, from the clear walker or the host word.
  always_ff @(posedge sys_clk) begin
    if (state == fcad_pkg::FCAD_CLEAR) coefficientRam[clearPtr] <= `FCAD_RST_COEF;
    else if (commit) coefficientRam[tapAddr] <= wordIn;
  end

  // Readout register follows the tap address while reading is enabled and no clear runs.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) readValue <= `FCAD_RST_COEF;
    else if (readEn && state == fcad_pkg::FCAD_IDLE) readValue <= coefficientRam[tapAddr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core.
  assign tdmSlotSelect       = {ctrl6[`FCAD_BIT_SLOT2], ctrl6[`FCAD_BIT_SLOT1], ctrl7[`FCAD_BIT_SLOT0]};
  assign attenRampSpeed      = ctrl7[`FCAD_BIT_RAMP_LO +: 2];
  assign zeroRunLengthSelect = detectCtl[`FCAD_BIT_ZRL_LO +: 2];
  assign autoFormatSwitchEn  = detectCtl[`FCAD_BIT_AUTOEN];
  assign clearBusy           = (state == fcad_pkg::FCAD_CLEAR);

  // Read mux; unmapped addresses read zero. Conversion mode sits in bit 6 of Control 3.
  always_comb begin
    case (rdAddr)
      `FCAD_ADDR_CTRL6:  rdData = ctrl6;
      `FCAD_ADDR_CTRL7:  rdData = ctrl7;
      `FCAD_ADDR_RSVD:   rdData = rsvd;
      `FCAD_ADDR_RAMCTL: rdData = ramCtl;
      `FCAD_ADDR_TAP:    rdData = tapAddr;
      `FCAD_ADDR_WHIGH:  rdData = writeValue[23:16];
      `FCAD_ADDR_WMID:   rdData = writeValue[15:8];
      `FCAD_ADDR_WLOW:   rdData = writeValue[7:0];
      `FCAD_ADDR_RHIGH:  rdData = readValue[23:16];
      `FCAD_ADDR_RMID:   rdData = readValue[15:8];
      `FCAD_ADDR_RLOW:   rdData = readValue[7:0];
      `FCAD_ADDR_DETECT: rdData = {detectCtl[7:5], 2'h0, detectedSpeedMode};
      `FCAD_ADDR_CTRL3:  rdData = {1'b0, actualConversionMode, 6'h00};
      default:           rdData = `FCAD_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Cycles spent in the clear walk; a stuck walker would starve host writes for good.
  logic [8:0] clearRun;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) clearRun <= 9'h000;
    else if (clearBusy) clearRun <= clearRun + 9'h001;
    else clearRun <= 9'h000;
  end

  // Write path into the coefficient RAM; a blocked write must leave the addressed word alone.
  a_write_blocked: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrLow && !writeEn && !clearBusy |=> coefficientRam[$past(tapAddr)] == $past(coefficientRam[tapAddr]))
    else $error("Coefficient write taken while disabled.");
  a_commit_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
    commit |=> coefficientRam[$past(tapAddr)] == {$past(writeValue[23:8]), $past(regWr.data)})
    else $error("Committed coefficient wrong.");
  a_ctl_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrRam |=> ramCtl == ($past(regWr.data) & `FCAD_RAMCTL_MASK))
    else $error("RAM control byte not masked.");

  // Clear walk: it starts on the strobe, zeroes one tap per cycle and ends after the last tap.
  a_clear_starts: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearGo && state == fcad_pkg::FCAD_IDLE |=> clearBusy && clearPtr == 8'h00) else $error("Clear did not start.");
  a_clear_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearBusy |=> coefficientRam[$past(clearPtr)] == `FCAD_RST_COEF)
    else $error("Clear left a tap unchanged.");
  a_clear_length: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearBusy |-> clearRun < 9'(TAPS))
    else $error("Clear walk too long.");
  a_clear_ends: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearBusy && clearPtr == 8'(TAPS - 1) |=> !clearBusy)
    else $error("Clear walk did not end.");
  a_clear_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearBusy && clearPtr != 8'(TAPS - 1) |=> clearBusy && clearPtr == $past(clearPtr) + 8'h01)
    else $error("Clear walk skipped a tap.");
  a_state_onehot: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state == fcad_pkg::FCAD_IDLE || state == fcad_pkg::FCAD_CLEAR)
    else $error("Clear sequencer state illegal.");
  a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !clearBusy |-> clearPtr == 8'h00)
    else $error("Clear pointer moved while idle.");

  // Readout path; the readout only tracks the RAM while reading is enabled and no clear runs.
  a_read_frozen: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !readEn |=> $stable(readValue)) else $error("Readout changed while reading disabled.");
  a_read_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    readEn && !clearBusy |=> readValue == $past(coefficientRam[tapAddr]))
    else $error("Readout does not follow the RAM.");
  a_read_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
    clearBusy |=> $stable(readValue))
    else $error("Readout changed during clear.");
  a_ro_ignored: assert property (@(posedge sys_clk) disable iff (!rst_b)
    regWr.wr && regWr.addr >= `FCAD_ADDR_RHIGH && regWr.addr <= `FCAD_ADDR_RLOW |=> $stable(writeValue))
    else $error("Readout write reached the coefficient bytes.");
  a_read_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_RHIGH |-> rdData == readValue[23:16])
    else $error("Readout high byte wrong.");
  a_read_mid: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_RMID |-> rdData == readValue[15:8])
    else $error("Readout middle byte wrong.");
  a_read_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_RLOW |-> rdData == readValue[7:0])
    else $error("Readout low byte wrong.");
  a_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr > `FCAD_ADDR_DETECT |-> rdData == `FCAD_RST_BYTE)
    else $error("Unmapped address read nonzero.");

  // Coefficient staging bytes and tap address.
  a_high_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrHigh |=> writeValue[23:16] == $past(regWr.data)) else $error("High byte not stored.");
  a_mid_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrMid |=> writeValue[15:8] == $past(regWr.data))
    else $error("Middle byte not stored.");
  a_low_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrLow |=> writeValue[7:0] == $past(regWr.data))
    else $error("Low byte not stored.");
  a_word_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrHigh && !wrMid && !wrLow |=> $stable(writeValue))
    else $error("Coefficient bytes changed unasked.");
  a_word_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_WHIGH |-> rdData == writeValue[23:16])
    else $error("High staging byte reads wrong.");
  a_tap_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrTap |=> tapAddr == $past(regWr.data)) else $error("Tap address not stored.");
  a_tap_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrTap |=> $stable(tapAddr))
    else $error("Tap address changed unasked.");
  a_tap_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_TAP |-> rdData == tapAddr)
    else $error("Tap address reads wrong.");

  // Slot select and ramp speed; the slot bits live in two bytes, so each write must spare the other's bits.
  a_slot_join: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrCtl7 && !wrCtl6 |=> tdmSlotSelect[0] == $past(regWr.data[`FCAD_BIT_SLOT0])
      && tdmSlotSelect[2:1] == $past(tdmSlotSelect[2:1])) else $error("Slot select mismatch.");
  a_slot_upper: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrCtl6 && !wrCtl7 |=> tdmSlotSelect[2] == $past(regWr.data[`FCAD_BIT_SLOT2])
      && tdmSlotSelect[1] == $past(regWr.data[`FCAD_BIT_SLOT1])) else $error("Upper slot bits wrong.");
  a_slot_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrCtl6 && !wrCtl7 |=> $stable(tdmSlotSelect))
    else $error("Slot select changed unasked.");
  a_ramp_speed: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrCtl7 |=> attenRampSpeed == $past(regWr.data[`FCAD_BIT_RAMP_LO +: 2])) else $error("Ramp speed wrong.");
  a_ramp_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrCtl7 |=> $stable(attenRampSpeed))
    else $error("Ramp speed changed unasked.");

  // Detection register, conversion mode readback and the reserved byte.
  a_detect_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_DETECT |-> rdData[2:0] == detectedSpeedMode) else $error("Speed mode readout wrong.");
  a_detect_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_DETECT |-> rdData[4:3] == 2'h0)
    else $error("Unused detection bits read nonzero.");
  a_auto_en: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrDet |=> autoFormatSwitchEn == $past(regWr.data[`FCAD_BIT_AUTOEN])) else $error("Auto switch enable wrong.");
  a_zero_run: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrDet |=> zeroRunLengthSelect == $past(regWr.data[`FCAD_BIT_ZRL_LO +: 2])) else $error("Zero run select wrong.");
  a_detect_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrDet |=> $stable(zeroRunLengthSelect) && $stable(autoFormatSwitchEn))
    else $error("Detection controls changed unasked.");
  a_mode_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_CTRL3 |-> rdData[`FCAD_BIT_CONV] == actualConversionMode)
    else $error("Conversion mode readout wrong.");
  a_mode_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rdAddr == `FCAD_ADDR_CTRL3 |-> rdData[5:0] == 6'h00 && !rdData[7])
    else $error("Conversion mode byte has stray bits.");
  a_rsvd_mask: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wrRsvd |=> (rsvd & ~`FCAD_RSVD_MASK) == 8'h00)
    else $error("Read-only reserved bits were stored.");
  a_rsvd_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !wrRsvd |=> $stable(rsvd))
    else $error("Reserved byte changed unasked.");

  // Main scenarios that the bench should reach.
  c_commit: cover property (@(posedge sys_clk) disable iff (!rst_b) commit);
  c_clear_done: cover property (@(posedge sys_clk) disable iff (!rst_b) clearBusy ##1 !clearBusy);
  c_readback: cover property (@(posedge sys_clk) disable iff (!rst_b) commit ##[1:4] readEn);
  c_blocked_low: cover property (@(posedge sys_clk) disable iff (!rst_b) wrLow && !writeEn && !clearBusy);
  c_clear_start: cover property (@(posedge sys_clk) disable iff (!rst_b) clearGo);
endmodule : fcad_regs

// ==== tb/fcad_host.sv ====
`timescale 1ns/1ns
//////////
// Host side of the control port: byte writes, combinational reads, coefficient loads.
module fcad_host (
  // Clock and read data.
  input  wire logic [7:0]         rdData,
  input  wire logic               sys_clk,
  // Access toward the device.
  output fcad_pkg::fcad_wr_s      regWr,
  output logic [7:0]              rdAddr
);
  // Idle bus until the first access.
  initial begin
    regWr = '0;
    rdAddr = 8'h00;
  end
  // Strobe stands one edge; data is inverted afterwards so stale bytes are never taken for good ones.
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    regWr = '{wr: 1'b1, addr: addr, data: data};
    @(posedge sys_clk);
    #1;
    regWr = '{wr: 1'b0, addr: addr, data: ~data};
  endtask : writeReg
  // Read data is combinational, so it is sampled late in the same cycle.
  task automatic readReg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    rdAddr = addr;
    #2;
    data = rdData;
  endtask : readReg
  // Address and enable go first, the low byte commits, then writing is shut again.
  task automatic loadCoef(input logic [7:0] tap, input logic [23:0] coef);
    writeReg(8'h0E, tap);
    writeReg(8'h0D, 8'h02);
    writeReg(8'h0F, coef[23:16]);
    writeReg(8'h10, coef[15:8]);
    writeReg(8'h11, coef[7:0]);
    writeReg(8'h0D, 8'h00);
  endtask : loadCoef
endmodule : fcad_host

// ==== tb/test_fcad_regs.sv ====
`timescale 1ns/1ns
//////////
module test_fcad_regs;
  logic               sys_clk = 1'b0;
  logic               rst_b = 1'b0;
  fcad_pkg::fcad_wr_s regWr;
  logic [7:0]         rdAddr;
  logic [7:0]         rdData;
  logic [7:0]         v;
  logic [2:0]         speed = 3'h0;
  logic [2:0]         slot;
  logic               conv = 1'b0;
  logic               autoEn;
  logic               clearBusy;
  logic [1:0]         ramp;
  logic [1:0]         zrl;
  int                 fail_count = 0;
  int                 tests_run = 0;
  // Clock of 4 ns.
  always #2 sys_clk = ~sys_clk;
  fcad_regs i_fcad_regs (.sys_clk(sys_clk), .rst_b(rst_b), .regWr(regWr), .rdAddr(rdAddr), .rdData(rdData),
    .detectedSpeedMode(speed), .actualConversionMode(conv), .tdmSlotSelect(slot), .attenRampSpeed(ramp),
    .zeroRunLengthSelect(zrl), .autoFormatSwitchEn(autoEn), .clearBusy(clearBusy));
  fcad_host i_fcad_host (.rdData(rdData), .sys_clk(sys_clk), .regWr(regWr), .rdAddr(rdAddr));
  //////////
  // Byte compare.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_fcad_host.readReg(a, v);
    chk(v, exp);
  endtask : rd
  task automatic test_done;
    $display("checks=%0d failures=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // A hang ends the run as a failure.
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  //////////
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    // Addresses 0x0B to 0x15 and the core controls read zero after reset.
    for (int a = 8'h0B; a <= 8'h15; a++) rd(8'(a), 8'h00);
    chk({slot, ramp, zrl, autoEn}, 8'h00);
    // Slot bits from two registers join into one select.
    i_fcad_host.writeReg(8'h0B, 8'hD0);
    i_fcad_host.writeReg(8'h0A, 8'h20);
    chk({slot, ramp, zrl, autoEn}, 8'h78);
    // Bytes written with the write enable off must not reach the RAM, so start from a cleared RAM.
    i_fcad_host.writeReg(8'h0D, 8'h01);
    for (int i = 0; i < 400 && clearBusy !== 1'b0; i++) @(posedge sys_clk);
    #1;
    chk({7'h00, clearBusy}, 8'h00);
    i_fcad_host.writeReg(8'h0E, 8'h05);
    i_fcad_host.writeReg(8'h0F, 8'h11);
    i_fcad_host.writeReg(8'h10, 8'h22);
    i_fcad_host.writeReg(8'h11, 8'h33);
    rd(8'h0F, 8'h11);
    i_fcad_host.writeReg(8'h0D, 8'h04);
    rd(8'h12, 8'h00);
    rd(8'h14, 8'h00);
    i_fcad_host.loadCoef(8'h05, 24'hABCDEF);
    i_fcad_host.writeReg(8'h0D, 8'h04);
    rd(8'h12, 8'hAB);
    rd(8'h13, 8'hCD);
    rd(8'h14, 8'hEF);
    // Clear runs for a bounded time and leaves the initial value behind.
    i_fcad_host.writeReg(8'h0D, 8'h01);
    chk({7'h00, clearBusy}, 8'h01);
    for (int i = 0; i < 400 && clearBusy !== 1'b0; i++) @(posedge sys_clk);
    #1;
    chk({7'h00, clearBusy}, 8'h00);
    rd(8'h0D, 8'h01);
    i_fcad_host.writeReg(8'h0D, 8'h04);
    rd(8'h12, 8'h00);
    rd(8'h14, 8'h00);
    // Detection status and controls share one register.
    speed = 3'h5;
    conv = 1'b1;
    i_fcad_host.writeReg(8'h15, 8'hFF);
    rd(8'h15, 8'hE5);
    rd(8'h02, 8'h40);
    chk({slot, ramp, zrl, autoEn}, 8'h7F);
    // Deliberate write of ones into the reserved register keeps only writable bits.
    i_fcad_host.writeReg(8'h0C, 8'hFF);
    rd(8'h0C, 8'h77);
    test_done();
  end
endmodule : test_fcad_regs
